// ===== rtl/uedma_pkg.sv
// constants for the usb endpoint dma slave
// Contract
// - ack-only bit clear selects fly-by mode with separate read and write strobes.
// - ack-only bit set selects acknowledge-only mode.
// - fly-by read strobe under acknowledge drives the endpoint's next byte or word.
// - fly-by write strobe under acknowledge captures the bus into the endpoint.
// - request is raised while the selected endpoint has data to move.
// - request drops after each beat in single mode, after burst end in burst.
// - no data drive without acknowledge; controller drops acknowledge after request.
// - ack-only mode uses acknowledge as strobe and ignores read and write strobes.
// - bulk transfer ends on pin, counter, short out packet, or enable cleared.
// - pin end on out endpoint discards rest of current buffer only.
// - pin end on in endpoint validates buffered packet for next in token.
// - 16-bit byte count register is loaded into counter when enable rises.
// - counter completion with counter end enabled halts dma.
// - short-packet end halts after the short out packet's bytes are moved.
// - bulk in short end occurs when counter hits zero mid buffer.
// - clearing enable halts the transfer without any event.
// - isochronous transfer ends on pin, counter, end of packet, or enable cleared.
// - endpoint comes from 4-bit index; its direction bit picks read or write.
// - acknowledge selects the configured dma endpoint regardless of io selection.
// - single-beat and burst transfers, bursts up to 16 bytes.
// - one dma endpoint at a time; io access may interleave.
package uedma_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_ENDPOINT_DIRECTION_BIT = 8'h0C;
    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    localparam int CFG_EN = 0;
    localparam int CFG_ACKONLY = 1;
    localparam int CFG_CNTEOT = 2;
    localparam int CFG_SHORTEOT = 3;
    localparam int CFG_BURST = 4;
    localparam int CFG_WIDE = 5;
    localparam int CFG_IDX_LO = 8;
    localparam int CFG_W = 12;
    localparam logic [11:0] CFG_RESET = 12'h000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] ENDPOINT_DIRECTION_BIT_RESET = 16'h0000;
    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    localparam int ST_ACTIVE = 0;
    localparam int ST_REQ = 1;
    localparam int ST_EXT = 2;
    localparam int ST_CNT = 3;
    localparam int ST_SHORT = 4;
    localparam int ST_EOP = 5;
    localparam int ST_REM_LO = 16;
    // ------------------------------------------------------------
    // transfer figures
    // ------------------------------------------------------------
    localparam int BURST_BYTES = 16;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
endpackage

// ===== rtl/uedma_core.sv
// usb endpoint dma slave: apb registers, pin handshake and end-of-transfer logic
`timescale 1ns/1ps
`default_nettype none
module uedma_core #(
    parameter int BURST = uedma_pkg::BURST_BYTES // bytes per burst
) (
    input wire logic clock, // 250 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output logic dma_request_out, // dma request pin
    input wire logic dma_acknowledge_in, // dma acknowledge pin
    input wire logic transfer_end_in, // external end-of-transfer pin
    input wire logic dma_read_strobe, // read strobe pin
    input wire logic dma_write_strobe, // write strobe pin
    input wire logic [15:0] data_in, // data bus level
    output logic [15:0] data_out, // data bus drive value
    output logic data_oe_n, // data bus enable, low while driving
    output logic [3:0] ep_sel, // endpoint selected for fifo access
    input wire logic rx_avail, // out endpoint holds data
    input wire logic [15:0] rx_data, // out endpoint head data
    input wire logic rx_short_last, // head is last of a short packet
    output logic rx_pop, // pulse: head consumed
    output logic rx_discard, // pulse: drop rest of current buffer
    input wire logic tx_space, // in endpoint can take data
    output logic [15:0] tx_data, // in endpoint write data
    output logic tx_push, // pulse: write tx_data
    output logic tx_validate, // pulse: mark packet for sending
    input wire logic ep_iso, // selected endpoint is isochronous
    input wire logic usb_eop // pulse: usb end of packet seen
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [19:0] pin_raw;
    logic [19:0] s1_q, s2_q, s3_q, flt_q, flt_d;
    assign pin_raw = {data_in, dma_write_strobe, dma_read_strobe, transfer_end_in,
                      dma_acknowledge_in};
    genvar gi;
    generate
        for (gi = 0; gi < 20; gi++) begin : g_sync
            always_comb begin
                flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
            end
        end
    endgenerate
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            flt_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
        end
    end
    logic ack_f, eot_f, rd_f, wr_f;
    logic [15:0] din_f;
    assign ack_f = flt_q[0];
    assign eot_f = flt_q[1];
    assign rd_f = flt_q[2];
    assign wr_f = flt_q[3];
    assign din_f = flt_q[19:4];
    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    logic [11:0] cfg_q, cfg_d;
    logic [15:0] count_q, count_d, endpoint_direction_bit_q, endpoint_direction_bit_d;
    logic [31:0] prdata_q, prdata_d, status_w;
    logic hit;
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;
    always_comb begin
        cfg_d = cfg_q;
        count_d = count_q;
        endpoint_direction_bit_d = endpoint_direction_bit_q;
        prdata_d = prdata_q;
        hit = (paddr == uedma_pkg::OFS_CFG) || (paddr == uedma_pkg::OFS_COUNT) ||
              (paddr == uedma_pkg::OFS_STATUS) || (paddr == uedma_pkg::OFS_ENDPOINT_DIRECTION_BIT);
        if (wr_acc && paddr == uedma_pkg::OFS_CFG) begin
            cfg_d = pwdata[11:0];
        end
        if (wr_acc && paddr == uedma_pkg::OFS_COUNT) begin
            count_d = pwdata[15:0];
        end
        if (wr_acc && paddr == uedma_pkg::OFS_ENDPOINT_DIRECTION_BIT) begin
            endpoint_direction_bit_d = pwdata[15:0];
        end
        if (psel && !penable) begin
            unique case (paddr)
                uedma_pkg::OFS_CFG: prdata_d = {20'h00000, cfg_q};
                uedma_pkg::OFS_COUNT: prdata_d = {16'h0000, count_q};
                uedma_pkg::OFS_STATUS: prdata_d = status_w;
                uedma_pkg::OFS_ENDPOINT_DIRECTION_BIT: prdata_d = {16'h0000, endpoint_direction_bit_q};
                default: prdata_d = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= uedma_pkg::CFG_RESET;
            count_q <= uedma_pkg::COUNT_RESET;
            endpoint_direction_bit_q <= uedma_pkg::ENDPOINT_DIRECTION_BIT_RESET;
            prdata_q <= 32'h00000000;
        end else begin
            cfg_q <= cfg_d;
            count_q <= count_d;
            endpoint_direction_bit_q <= endpoint_direction_bit_d;
            prdata_q <= prdata_d;
        end
    end
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    // ------------------------------------------------------------
    // dma engine
    // ------------------------------------------------------------
    logic en, ack_only, cnt_en, short_en, burst, wide, dir_in;
    logic [3:0] idx;
    assign en = cfg_q[uedma_pkg::CFG_EN];
    assign ack_only = cfg_q[uedma_pkg::CFG_ACKONLY];
    assign cnt_en = cfg_q[uedma_pkg::CFG_CNTEOT];
    assign short_en = cfg_q[uedma_pkg::CFG_SHORTEOT];
    assign burst = cfg_q[uedma_pkg::CFG_BURST];
    assign wide = cfg_q[uedma_pkg::CFG_WIDE];
    assign idx = cfg_q[uedma_pkg::CFG_IDX_LO +: 4];
    assign dir_in = endpoint_direction_bit_q[idx];
    logic en_q, act_q, act_d, strb_q, req_q, req_d, hold_q, hold_d;
    logic [15:0] cnt_q, cnt_d, dout_q, dout_d, tdat_q, tdat_d, step;
    logic [4:0] bcnt_q, bcnt_d;
    logic [3:0] why_q, why_d;
    logic pop_d, push_d, disc_d, val_d, eot_q;
    logic strobe, fall, beat, hit0, end_ext, end_cnt, end_short, end_eop, any_end;
    always_comb begin
        // fly-by uses the strobe matching the direction
        strobe = ack_only ? ack_f : (ack_f && (dir_in ? wr_f : rd_f));
        fall = strb_q && !strobe;
        beat = fall && act_q;
        step = wide ? uedma_pkg::STEP_WORD : uedma_pkg::STEP_BYTE;
        hit0 = cnt_q <= step;
        end_ext = eot_f && !eot_q && act_q;
        end_cnt = beat && hit0 && (cnt_en || (short_en && dir_in));
        end_short = beat && short_en && !dir_in && rx_short_last;
        end_eop = usb_eop && ep_iso && act_q;
        any_end = end_ext || end_cnt || end_short || end_eop;
        act_d = act_q;
        cnt_d = cnt_q;
        why_d = why_q;
        if (beat) begin
            cnt_d = hit0 ? 16'h0000 : cnt_q - step;
        end
        if (en && !en_q) begin
            act_d = 1'b1;
            cnt_d = count_q;
            why_d = 4'h0;
        end else if (any_end) begin
            act_d = 1'b0;
        end
        why_d = why_d | {end_eop, end_short, end_cnt, end_ext};
        if (!en) begin
            act_d = 1'b0;
        end
        bcnt_d = bcnt_q;
        hold_d = hold_q;
        // ack-only drops ack between beats, so only idle or a finished burst clears the tally
        if (!act_q || (ack_only ? (hold_q && !ack_f) : !ack_f)) begin
            bcnt_d = 5'h00;
            hold_d = 1'b0;
        end else if (beat) begin
            bcnt_d = bcnt_q + 5'(step);
            // request drops per beat or at burst end
            if (!burst || int'(bcnt_d) >= BURST) begin
                hold_d = 1'b1;
            end
        end
        // request only while enabled, active and data can move
        req_d = act_d && !any_end && !hold_d && (dir_in ? tx_space : rx_avail);
        // present next head at strobe start
        dout_d = (strobe && !strb_q && !dir_in) ? rx_data : dout_q;
        tdat_d = (beat && dir_in) ? din_f : tdat_q;
        push_d = beat && dir_in;
        pop_d = beat && !dir_in;
        // drop rest of current out buffer
        disc_d = end_ext && !dir_in;
        val_d = dir_in && (end_ext || end_cnt);
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
            act_q <= 1'b0;
            strb_q <= 1'b0;
            req_q <= 1'b0;
            hold_q <= 1'b0;
            eot_q <= 1'b0;
            cnt_q <= 16'h0000;
            dout_q <= 16'h0000;
            tdat_q <= 16'h0000;
            bcnt_q <= 5'h00;
            why_q <= 4'h0;
            rx_pop <= 1'b0;
            tx_push <= 1'b0;
            rx_discard <= 1'b0;
            tx_validate <= 1'b0;
        end else begin
            en_q <= en;
            act_q <= act_d;
            strb_q <= strobe;
            req_q <= req_d;
            hold_q <= hold_d;
            eot_q <= eot_f;
            cnt_q <= cnt_d;
            dout_q <= dout_d;
            tdat_q <= tdat_d;
            bcnt_q <= bcnt_d;
            why_q <= why_d;
            rx_pop <= pop_d;
            tx_push <= push_d;
            rx_discard <= disc_d;
            tx_validate <= val_d;
        end
    end
    assign dma_request_out = req_q;
    assign data_out = dout_q;
    assign tx_data = tdat_q;
    // drive only under acknowledge during a read beat
    assign data_oe_n = !(strobe && !dir_in);
    // endpoint select always follows the configured dma endpoint index, with or without acknowledge
    assign ep_sel = idx;
    assign status_w = {cnt_q, 10'h000, why_q, req_q, act_q};
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_read_beat;
        (strobe && !dir_in && act_q) ##1 (!strobe && act_q);
    endsequence
    sequence s_write_beat;
        (strobe && dir_in && act_q) ##1 (!strobe && act_q);
    endsequence
    a_req_when_off: assert property (@(posedge clock) disable iff (!rst_n)
        !en |=> !dma_request_out) else $error("request while disabled");
    a_drive_needs_ack: assert property (@(posedge clock) disable iff (!rst_n)
        !data_oe_n |-> ack_f && !dir_in) else $error("drive without acknowledge");
    a_ackonly_strobe: assert property (@(posedge clock) disable iff (!rst_n)
        (ack_only && ack_f && !rd_f && !wr_f) |=> strb_q) else $error("ack not strobe");
    a_read_pops: assert property (@(posedge clock) disable iff (!rst_n)
        s_read_beat |=> rx_pop) else $error("read beat without pop");
    a_write_pushes: assert property (@(posedge clock) disable iff (!rst_n)
        s_write_beat |=> tx_push && tx_data == $past(din_f)) else $error("write lost");
    a_single_drop: assert property (@(posedge clock) disable iff (!rst_n)
        ((rx_pop || tx_push) && !burst && ack_f) |-> !dma_request_out)
        else $error("request held in single mode");
    a_count_load: assert property (@(posedge clock) disable iff (!rst_n)
        (en && !en_q) |=> cnt_q == $past(count_q) && act_q) else $error("count not loaded");
    a_count_halt: assert property (@(posedge clock) disable iff (!rst_n)
        (beat && cnt_en && hit0) |=> !act_q ##1 !dma_request_out) else $error("no halt");
    a_ext_discard: assert property (@(posedge clock) disable iff (!rst_n)
        (end_ext && !dir_in) |=> rx_discard && !act_q) else $error("out end not dropped");
    a_ext_validate: assert property (@(posedge clock) disable iff (!rst_n)
        (end_ext && dir_in) |=> tx_validate && !act_q) else $error("in end not sent");
    a_disable_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        (en_q && !en && !any_end) |=> !act_q && !tx_validate && !rx_discard)
        else $error("disable raised event");
    a_short_halt: assert property (@(posedge clock) disable iff (!rst_n)
        end_short |=> !act_q && !dma_request_out) else $error("short packet kept running");
    a_eop_halt: assert property (@(posedge clock) disable iff (!rst_n)
        end_eop |=> !act_q && !dma_request_out) else $error("end of packet kept running");
    a_ext_stop: assert property (@(posedge clock) disable iff (!rst_n)
        end_ext |=> !act_q && !dma_request_out) else $error("end pin kept running");
    a_off_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !en |=> !act_q) else $error("active while disabled");
    a_burst_drop: assert property (@(posedge clock) disable iff (!rst_n)
        (beat && burst && !hold_q && (ack_only || ack_f) &&
        int'(bcnt_q) + int'(step) >= BURST) |=> !dma_request_out) else $error("burst too long");
    a_read_data: assert property (@(posedge clock) disable iff (!rst_n)
        (strobe && !strb_q && !dir_in) |=> data_out == $past(rx_data))
        else $error("read data not presented");
    a_ackonly_ignore: assert property (@(posedge clock) disable iff (!rst_n)
        ack_only |-> strobe == ack_f) else $error("strobe pins not ignored");
    a_count_step: assert property (@(posedge clock) disable iff (!rst_n)
        (beat && !hit0) |=> cnt_q == $past(cnt_q) - $past(step))
        else $error("count not stepped");
endmodule
`default_nettype wire

// ===== sim/uedma_dma_ctl.sv
// external dma controller model for the endpoint dma port
`timescale 1ns/1ps
`default_nettype none
module uedma_dma_ctl (
    input wire logic clock, // bench clock
    input wire logic run, // allow new sessions
    input wire logic ack_only, // acknowledge is the strobe
    input wire logic is_in, // write beats
    input wire logic wide, // 16-bit beats
    input wire logic [3:0] hold, // strobe high cycles
    input wire logic dma_request_out, // device request
    input wire logic data_oe_n, // device bus enable
    input wire logic [15:0] data_out, // device drive value
    output logic dma_acknowledge_in, // acknowledge pin
    output logic dma_read_strobe, // read strobe pin
    output logic dma_write_strobe, // write strobe pin
    output logic [15:0] data_in, // bus level
    output logic [15:0] beats, // beats done
    output logic [15:0] addr, // memory address
    output logic [15:0] k_max, // longest burst
    output logic [15:0] rd_sum, // xor of words taken
    output logic [15:0] wr_sum, // xor of words given
    output logic bad // wrong bus enable at a beat
);
    logic sess = 1'b0;
    logic st = 1'b0;
    logic [15:0] k;
    logic [15:0] w;
    assign dma_acknowledge_in = ack_only ? st : sess;
    assign dma_read_strobe = st & ~ack_only & ~is_in;
    assign dma_write_strobe = st & ~ack_only & is_in;
    initial begin
        {data_in, beats, addr, k_max, rd_sum, wr_sum} = {16'hA5C3, 80'h0};
        bad = 1'b0;
        forever begin
            @(posedge clock);
            if (run && dma_request_out) begin
                sess <= 1'b1;
                k = 16'h0000;
                repeat (2) @(posedge clock);
                do begin
                    data_in <= data_in + 16'h3C5B;
                    st <= 1'b1;
                    repeat (hold) @(posedge clock);
                    if (is_in) begin
                        wr_sum <= wr_sum ^ data_in;
                        bad <= bad | ~data_oe_n;
                    end else begin
                        rd_sum <= rd_sum ^ data_out;
                        bad <= bad | data_oe_n;
                    end
                    st <= 1'b0;
                    beats <= beats + 16'h0001;
                    addr <= addr + (wide ? 16'h0002 : 16'h0001);
                    k = k + 16'h0001;
                    w = 16'h0000;
                    while (dma_request_out && w < 16'h000A) begin
                        @(posedge clock);
                        w = w + 16'h0001;
                    end
                end while (dma_request_out && k < 16'h0028);
                if (k > k_max) k_max <= k;
                // acknowledge dropped after request, bus released
                sess <= 1'b0;
                data_in <= ~data_in;
                repeat (6) @(posedge clock);
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/usb_endpoint_dma_slave_tb.sv
// self-checking bench for the usb endpoint dma slave
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_dma_slave_tb;
    typedef struct {
        logic [11:0] cfg;
        logic dir, iso;
        logic [15:0] cnt;
        int stop, at, sh, nb, eb, disc, val, mb;
    } uedma_case_t;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, dma_request_out;
    logic dma_acknowledge_in, transfer_end_in, dma_read_strobe, dma_write_strobe;
    logic data_oe_n, rx_avail, rx_pop, rx_discard, tx_space, tx_push, tx_validate;
    logic ep_iso, usb_eop, run, ack_only, is_in, wide, bad, oe_bad = 1'b0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] data_in, data_out, rx_data, tx_data, beats, k_max, rd_sum, wr_sum;
    logic [15:0] rx_sum = 16'h0000, tx_sum = 16'h0000;
    logic [3:0] ep_sel, hold;
    int n_errors = 0, samples_checked = 0, pops = 0, pushes = 0, discs = 0, vlds = 0;
    int late = 0, sh = 0;
    uedma_case_t cs [10];
    wire logic rx_short_last = (sh > 0) && (pops == sh - 1);
    uedma_core u_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .dma_request_out, .dma_acknowledge_in, .transfer_end_in,
        .dma_read_strobe, .dma_write_strobe, .data_in, .data_out, .data_oe_n, .ep_sel,
        .rx_avail, .rx_data, .rx_short_last, .rx_pop, .rx_discard, .tx_space, .tx_data,
        .tx_push, .tx_validate, .ep_iso, .usb_eop);
    uedma_dma_ctl u_ctl (.clock, .run, .ack_only, .is_in, .wide, .hold, .dma_request_out,
        .data_oe_n, .data_out, .dma_acknowledge_in, .dma_read_strobe, .dma_write_strobe,
        .data_in, .beats, .addr(), .k_max, .rd_sum, .wr_sum, .bad);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ------------------------------------------------------------
    // endpoint fifo side and bus watch
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (rx_pop) begin
            rx_sum <= rx_sum ^ rx_data;
            rx_data <= 16'($urandom);
            pops <= pops + 1;
        end
        if (tx_push) begin
            tx_sum <= tx_sum ^ tx_data;
            pushes <= pushes + 1;
        end
        if (rx_discard) discs <= discs + 1;
        if (tx_validate) vlds <= vlds + 1;
        late <= (!dma_acknowledge_in && !data_oe_n) ? late + 1 : 0;
        if (late > 5) oe_bad <= 1'b1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, m, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic tmo();
        n_errors++;
        $display("Error at %0t: wait ran out", $time);
        print_verdict();
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int t;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) tmo();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    // ------------------------------------------------------------
    // one transfer from enable to end
    // ------------------------------------------------------------
    task automatic run_case(input uedma_case_t c);
        logic [31:0] r;
        logic e;
        logic [3:0] idx;
        logic [15:0] b0, dirs;
        int t, hi, stp;
        idx = 4'($urandom_range(15, 1));
        dirs = 16'($urandom);
        dirs[idx] = c.dir;
        stp = c.cfg[uedma_pkg::CFG_WIDE] ? 2 : 1;
        wr(uedma_pkg::OFS_CFG, 32'h0000_0000);
        rx_avail <= 1'b0;
        tx_space <= 1'b0;
        ack_only <= c.cfg[uedma_pkg::CFG_ACKONLY];
        is_in <= c.dir;
        wide <= c.cfg[uedma_pkg::CFG_WIDE];
        ep_iso <= c.iso;
        hold <= 4'($urandom_range(10, 6));
        sh = c.sh;
        {pops, pushes, discs, vlds} <= '0;
        wr(uedma_pkg::OFS_ENDPOINT_DIRECTION_BIT, {16'h0000, dirs});
        wr(uedma_pkg::OFS_COUNT, {16'h0000, c.cnt});
        apb(uedma_pkg::OFS_COUNT, 1'b0, 32'h0, r, e);
        check(r, {16'h0000, c.cnt}, "count readback");
        wr(uedma_pkg::OFS_CFG, {20'h00000, c.cfg | {idx, 8'h01}});
        repeat (10) @(posedge clock);
        check(ep_sel, idx, "endpoint select");
        check(dma_request_out, 1'b0, "request without data");
        b0 = beats;
        rx_avail <= 1'b1;
        tx_space <= 1'b1;
        run <= 1'b1;
        t = 0;
        while (beats - b0 < c.nb && t < 4000) begin
            @(posedge clock);
            t++;
        end
        if (t >= 4000) tmo();
        run <= 1'b0;
        repeat (30) @(posedge clock);
        transfer_end_in <= (c.stop == 1);
        usb_eop <= (c.stop == 2);
        @(posedge clock);
        usb_eop <= 1'b0;
        repeat (5) @(posedge clock);
        transfer_end_in <= 1'b0;
        if (c.stop == 3) wr(uedma_pkg::OFS_CFG, {20'h00000, c.cfg | {idx, 8'h00}});
        repeat (20) @(posedge clock);
        hi = 0;
        repeat (20) begin
            @(posedge clock);
            if (dma_request_out !== 1'b0) hi++;
        end
        check(hi, 0, "request after end");
        apb(uedma_pkg::OFS_STATUS, 1'b0, 32'h0, r, e);
        check(r[uedma_pkg::ST_ACTIVE], 1'b0, "still active");
        check(r[uedma_pkg::ST_REQ], 1'b0, "request flag");
        if (c.eb >= 0) check(r[c.eb], 1'b1, "end reason");
        check(r[31:16], 16'(c.cnt - c.nb * stp), "remaining count");
        check(beats - b0, c.nb, "beats");
        check(c.dir ? pushes : pops, c.nb, "fifo moves");
        check(discs, c.disc, "discards");
        check(vlds, c.val, "validates");
        check(k_max, c.mb, "burst length");
        check(rd_sum, rx_sum, "read data");
        check(wr_sum, tx_sum, "write data");
        check({bad, oe_bad}, 2'b00, "bus enable");
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        logic [15:0] c0;
        void'($urandom(32'h5A03));
        {rst_n, psel, penable, pwrite, run, ack_only, is_in, wide, ep_iso, usb_eop} = '0;
        {transfer_end_in, rx_avail, tx_space, hold, paddr, pwdata} = {3'b011, 44'h6};
        rx_data = 16'($urandom);
        c0 = 16'($urandom_range(8, 1));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (20) @(posedge clock);
        check(dma_request_out, 1'b0, "request while disabled");
        foreach (cs[i]) begin
            apb(8'(4 * (i % 4)), 1'b0, 32'h0, r, e);
            check(r, 32'h0000_0000, "reset value");
        end
        wr(uedma_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        apb(uedma_pkg::OFS_STATUS, 1'b0, 32'h0, r, e);
        check(r, 32'h0000_0000, "status read only");
        apb(8'h10, 1'b0, 32'h0, r, e);
        check({e, r}, {1'b1, 32'h0}, "unmapped");
        cs = '{'{12'h004, 0, 0, c0, 0, 0, 0, c0, uedma_pkg::ST_CNT, 0, 0, 1},
               '{12'h004, 1, 0, 16'h0004, 0, 0, 0, 4, uedma_pkg::ST_CNT, 0, 1, 1},
               '{12'h016, 0, 0, 16'h0028, 0, 0, 0, 40, uedma_pkg::ST_CNT, 0, 0, 16},
               '{12'h026, 1, 0, 16'h000C, 0, 0, 0, 6, uedma_pkg::ST_CNT, 0, 1, 16},
               '{12'h018, 0, 0, 16'h00C8, 0, 0, 3, 3, uedma_pkg::ST_SHORT, 0, 0, 16},
               '{12'h008, 1, 0, 16'h0005, 0, 0, 0, 5, -1, 0, 1, 16},
               '{12'h000, 0, 0, 16'h00C8, 1, 2, 0, 2, uedma_pkg::ST_EXT, 1, 0, 16},
               '{12'h002, 1, 0, 16'h00C8, 1, 3, 0, 3, uedma_pkg::ST_EXT, 0, 1, 16},
               '{12'h000, 0, 0, 16'h00C8, 3, 2, 0, 2, -1, 0, 0, 16},
               '{12'h000, 0, 1, 16'h00C8, 2, 2, 0, 2, uedma_pkg::ST_EOP, 0, 0, 16}};
        // modes and end sources in turn
        foreach (cs[i]) run_case(cs[i]);
        print_verdict();
    end
endmodule
`default_nettype wire
